// *** dv/fifo_port_retransmit_offset_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for fpr_ctrl at its default depth.
// Assumes: The read rate select changes only while reset is held.
// Notes: Double rate reads and fall through timing run last, after a fresh reset.
`timescale 1ns/1ns
`include "fpr_map.svh"
`define CHK(n, e, a) begin \
  compares++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("wrong value %s exp %h got %h", n, e, a); \
  end \
end
module fifo_port_retransmit_offset_ctrl_tb_top;
  logic clk = 1'h0, rd_clk = 1'h0, rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  fpr_pkg::fpr_wr_s wr_port = {2'h3, 40'h0};
  logic partial_clear_n = 1'h1, rd_en_n = 1'h1, retransmit_n = 1'h1, mark = 1'h0;
  logic read_single_rate_sel = 1'h0;
  logic pready, pslverr, sclk, offset_load_en_n, offset_readback_en_n, serial_in, serial_out;
  logic almost_empty_n, almost_full_n, full_flag_n, empty_flag_n, output_ready, err;
  logic [31:0] prdata, q;
  logic [39:0] rd_data, rd_data_fall;
  logic [27:0] g;
  int fail_count = 0, compares = 0, cycles = 0;
  fpr_ctrl i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wr_port, .partial_clear_n, .sclk, .offset_load_en_n,
    .offset_readback_en_n, .serial_in, .serial_out, .almost_empty_n, .almost_full_n,
    .full_flag_n, .rd_clk, .rd_en_n, .read_single_rate_sel, .retransmit_n, .mark, .rd_data,
    .rd_data_fall, .empty_flag_n, .output_ready);
  fpr_host i_host (.clk, .sclk, .offset_load_en_n, .offset_readback_en_n, .serial_in,
    .serial_out);
  always #25 clk = ~clk;
  // The read clock starts off phase and runs a 64 ns period against 50 ns, so its edges drift against clk.
  initial begin
    #7;
    forever #32 rd_clk = ~rd_clk;
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic en_n, input logic sel_n, input logic [39:0] d);
    @(posedge clk);
    wr_port <= {en_n, sel_n, d};
    @(posedge clk);
    wr_port <= {2'h3, d};
  endtask : wr
  task automatic rd(input logic [39:0] w);
    do @(posedge rd_clk); while (empty_flag_n !== 1'h1);
    rd_en_n <= 1'h0;
    @(posedge rd_clk);
    rd_en_n <= 1'h1;
    @(posedge rd_clk);
    #1;
    `CHK("word", w, rd_data)
  endtask : rd
  task automatic rt(input logic fw);
    @(posedge rd_clk);
    retransmit_n <= 1'h0;
    @(posedge rd_clk);
    retransmit_n <= 1'h1;
    #1;
    `CHK("empty flag", fw, empty_flag_n)
    `CHK("output ready", fw, output_ready)
  endtask : rt
  task automatic mk;
    @(posedge rd_clk);
    mark <= 1'h1;
    @(posedge rd_clk);
    mark <= 1'h0;
  endtask : mk
  task automatic t_serial;
    apb(1'h0, 12'h010, 32'h0);
    `CHK("unmapped", 1'h1, err)
    i_host.shift(1'h1, {14'h3, 14'h2}, g);
    apb(1'h0, `FPR_OFS_EMPTY_OFS, 32'h0);
    `CHK("empty ofs", 32'h3, q)
    i_host.shift(1'h0, 28'h0, g);
    `CHK("chain", {14'h3, 14'h2}, g)
  endtask : t_serial
  task automatic t_write;
    wr(1'h0, 1'h1, 40'hee);
    wr(1'h1, 1'h0, 40'hee);
    for (int i = 0; i < 3; i++) begin
      wr(1'h0, 1'h0, 40'h10 + 40'(i));
      repeat (6) @(posedge clk);
      `CHK("almost empty", i == 2, almost_empty_n)
    end
    `CHK("almost full", 1'h1, almost_full_n)
    apb(1'h1, `FPR_OFS_CTRL, 32'h2);
    wr(1'h0, 1'h0, 40'h13);
    apb(1'h1, `FPR_OFS_CTRL, 32'h0);
    apb(1'h0, `FPR_OFS_STATUS, 32'h0);
    `CHK("count", 15'h5, q[14:0])
  endtask : t_write
  task automatic t_retx;
    rd(40'h10);
    mk();
    rd(40'h11);
    mk();
    rd(40'h12);
    rt(1'h0);
    repeat (20) @(posedge clk);
    apb(1'h0, `FPR_OFS_STATUS, 32'h0);
    `CHK("count", 15'h3, q[14:0])
    apb(1'h0, `FPR_OFS_FULL_OFS, 32'h0);
    `CHK("full ofs", 32'h2, q)
    wr(1'h0, 1'h0, 40'h14);
    rd(40'h12);
    rd(40'h13);
    rd(40'h13);
    rd(40'h14);
  endtask : t_retx
  task automatic t_clear;
    @(posedge clk);
    partial_clear_n <= 1'h0;
    repeat (8) @(posedge clk);
    partial_clear_n <= 1'h1;
    repeat (10) @(posedge clk);
    `CHK("output", 40'h0, rd_data)
    apb(1'h0, `FPR_OFS_EMPTY_OFS, 32'h0);
    `CHK("empty ofs", 32'h3, q)
    wr(1'h0, 1'h0, 40'h15);
    wr(1'h0, 1'h0, 40'h16);
    rd(40'h15);
    rt(1'h0);
    rd(40'h15);
  endtask : t_clear
  task automatic t_ddr;
    @(posedge clk);
    rst <= 1'h1;
    read_single_rate_sel <= 1'h1;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    apb(1'h1, `FPR_OFS_CTRL, 32'h1);
    wr(1'h0, 1'h0, 40'h21);
    wr(1'h0, 1'h0, 40'h22);
    repeat (20) @(posedge clk);
    rd(40'h21);
    `CHK("second word", 40'h22, rd_data_fall)
    rt(1'h1);
    rd(40'h21);
    `CHK("second word", 40'h22, rd_data_fall)
  endtask : t_ddr
  task automatic wrap_up;
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    t_serial();
    t_write();
    t_retx();
    t_clear();
    t_ddr();
    wrap_up();
  end
endmodule : fifo_port_retransmit_offset_ctrl_tb_top

// *** dv/fpr_ctrl_asserts.sv ***
// Purpose: Port checks on fpr_ctrl.
// Assumes: Standard timing mode and offsets loaded before any partial clear.
// Notes: Serial pins pass two flops, so quiet spans are four cycles long.
`timescale 1ns/1ns
module fpr_ctrl_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic partial_clear_n,
  input wire logic offset_load_en_n,
  input wire logic offset_readback_en_n,
  input wire logic serial_out,
  input wire logic almost_empty_n,
  input wire logic almost_full_n,
  input wire logic rd_clk,
  input wire logic retransmit_n,
  input wire logic empty_flag_n,
  input wire logic output_ready
);
  chk_apb_answer: assert property (@(posedge clk) disable iff (rst)
    psel && !penable |-> !pready ##1 pready) else $error("no answer after setup");
  chk_ready_pulse: assert property (@(posedge clk) disable iff (rst)
    pready |=> !pready) else $error("ready held too long");
  chk_err_map: assert property (@(posedge clk) disable iff (rst)
    pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
    else $error("error flag wrong");
  chk_err_ready: assert property (@(posedge clk) disable iff (rst)
    pslverr |-> pready) else $error("error without ready");
  chk_serial_quiet: assert property (@(posedge clk) disable iff (rst)
    (offset_readback_en_n && offset_load_en_n && !psel)[*4] |=> $stable(serial_out))
    else $error("serial output moved while idle");
  chk_clear_flags: assert property (@(posedge clk) disable iff (rst)
    (!partial_clear_n)[*6] |=> !almost_empty_n && almost_full_n)
    else $error("level flags wrong after clear");
  chk_clear_empty: assert property (@(posedge rd_clk) disable iff (rst)
    (!partial_clear_n)[*4] |=> !empty_flag_n) else $error("not empty after clear");
  chk_rt_flag: assert property (@(posedge rd_clk) disable iff (rst)
    !retransmit_n |=> empty_flag_n == output_ready) else $error("flag wrong after retransmit");
endmodule : fpr_ctrl_asserts
bind fpr_ctrl fpr_ctrl_asserts u_chk (.clk, .rst, .psel, .penable, .paddr, .pready, .pslverr,
  .partial_clear_n, .offset_load_en_n, .offset_readback_en_n, .serial_out, .almost_empty_n,
  .almost_full_n, .rd_clk, .retransmit_n, .empty_flag_n, .output_ready);

// *** dv/fpr_host.sv ***
// Purpose: Offset programming host on the serial pins.
// Assumes: sclk runs far below a quarter of clk.
// Notes: sclk rests low between frames; serial_in flips when idle.
`timescale 1ns/1ns
module fpr_host (
  input wire logic clk,
  output logic sclk = 1'h0,
  output logic offset_load_en_n = 1'h1,
  output logic offset_readback_en_n = 1'h1,
  output logic serial_in = 1'h0,
  input wire logic serial_out
);
  // Both directions walk one chain, empty offset first, MSB first.
  task automatic shift(input logic ld, input logic [27:0] v, output logic [27:0] got);
    for (int i = 27; i >= 0; i--) begin
      @(posedge clk);
      offset_load_en_n <= !ld;
      offset_readback_en_n <= ld;
      serial_in <= v[i];
      repeat (8) @(posedge clk);
      sclk <= 1'h1;
      repeat (8) @(posedge clk);
      got[i] = serial_out;
      sclk <= 1'h0;
    end
    @(posedge clk);
    offset_load_en_n <= 1'h1;
    offset_readback_en_n <= 1'h1;
    serial_in <= !serial_in;
  endtask : shift
endmodule : fpr_host

// *** rtl/fpr_ctrl.sv ***
// Purpose: Port control of a dual clock 40-bit FIFO with mark, retransmit and serial offsets.
// Assumes: clk is the write and register clock; rd_clk is the reader's clock.
// Notes: Pointers cross between domains by a request and acknowledge handshake.
// Notes on behaviour
// RULE1: Read rate select low single, high double.
// RULE2: Reader holds read rate select fixed.
// RULE3: Retransmit without mark reloads read pointer zero.
// RULE4: Retransmit drops empty flag, raises output ready. Code sets both flags to the fall through mode bit.
// RULE5: Retransmit leaves write side and offsets alone.
// RULE6: Retransmit with mark reloads marked position.
// RULE7: Serial clock edge shifts serial input when loading.
// RULE8: Serial clock edge shifts chain out when reading.
// RULE9: Double rate write stores on both edges.
// RULE10: Single rate write stores on rising edge.
// RULE11: Write needs enable and select both low.
// RULE12: Mark captures read pointer; latest capture kept.
// RULE13: Partial clear zeroes pointers, output; keeps settings.
// RULE14: Almost empty high when count reaches offset.
// RULE15: Almost full high while free exceeds offset.
// RULE16: Empty then full offset form one chain.
// RULE17: Retransmit pointer change crosses into write domain.
`timescale 1ns/1ns
`include "fpr_map.svh"

module fpr_xfer #(
  parameter int W = 15
) (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic [W-1:0] src_val,
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic [W-1:0] dst_val
);
  logic [W-1:0] hold_q;
  logic req_q, ack_s1_q, ack_s2_q, req_s1_q, req_s2_q, seen_q;
  // The held word stays still until the far side has taken it.
  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      hold_q <= '0;
      req_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= seen_q;
      ack_s2_q <= ack_s1_q;
      if (ack_s2_q == req_q) begin
        hold_q <= src_val;
        req_q <= ~req_q;
      end
    end
  end
  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      seen_q <= 1'b0;
      dst_val <= '0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      if (req_s2_q != seen_q) begin
        dst_val <= hold_q;
        seen_q <= req_s2_q;
      end
    end
  end
endmodule : fpr_xfer

module fpr_ctrl
  import fpr_pkg::*;
#(
  parameter int DATA_W = `FPR_DATA_W,
  parameter int ADDR_W = `FPR_ADDR_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`FPR_APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fpr_wr_s wr_port,
  input wire logic partial_clear_n,
  input wire logic sclk,
  input wire logic offset_load_en_n,
  input wire logic offset_readback_en_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic almost_empty_n,
  output logic almost_full_n,
  output logic full_flag_n,
  input wire logic rd_clk,
  input wire logic rd_en_n,
  input wire logic read_single_rate_sel,
  input wire logic retransmit_n,
  input wire logic mark,
  output logic [DATA_W-1:0] rd_data,
  output logic [DATA_W-1:0] rd_data_fall,
  output logic empty_flag_n,
  output logic output_ready
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam fpr_ptr_t DEPTH_P = fpr_ptr_t'(DEPTH);

  logic [DATA_W-1:0] mem [DEPTH];

  // Pin synchronisers in the write domain.
  logic [1:0] pc_s_q, sck_s_q, ld_s_q, rb_s_q, si_s_q;
  logic sck_old_q;
  always_ff @(posedge clk) begin
    pc_s_q <= {pc_s_q[0], partial_clear_n};
    sck_s_q <= {sck_s_q[0], sclk};
    ld_s_q <= {ld_s_q[0], offset_load_en_n};
    rb_s_q <= {rb_s_q[0], offset_readback_en_n};
    si_s_q <= {si_s_q[0], serial_in};
    sck_old_q <= sck_s_q[1];
  end
  logic wclr, sck_rise;
  assign wclr = rst | ~pc_s_q[1];
  assign sck_rise = sck_s_q[1] & ~sck_old_q;

  // Falling edge capture lets the double rate mode store two words per period.
  logic [DATA_W-1:0] neg_data_q;
  logic neg_we_q;
  logic [DATA_W-1:0] neg_data;
  assign neg_data = neg_data_q;
  always_ff @(negedge clk) begin
    neg_data_q <= wr_port.data;
    neg_we_q <= ~wr_port.en_n & ~wr_port.sel_n; // see RULE11
  end

  // Write domain state.
  fpr_cfg_s cfg_q, cfg_d;
  logic [ADDR_W-1:0] eofs_q, eofs_d, fofs_q, fofs_d;
  fpr_ptr_t wptr_q, wptr_d, rptr_w;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, so_d, ae_d, af_d, ff_d;
  logic we_rise, we_fall, apb_wr;
  fpr_ptr_t count, free_w;
  logic [2*ADDR_W-1:0] chain;

  assign count = wptr_q - rptr_w;
  assign free_w = DEPTH_P - count;
  assign chain = {eofs_q, fofs_q}; // see RULE16
  assign apb_wr = psel & penable & pready & pwrite;

  always_comb begin
    cfg_d = cfg_q;
    eofs_d = eofs_q;
    fofs_d = fofs_q;
    wptr_d = wptr_q;
    so_d = serial_out;
    // Falling edge word is older, so it is stored first.
    we_fall = cfg_q.wddr & neg_we_q & (free_w != '0); // see RULE9
    we_rise = ~wr_port.en_n & ~wr_port.sel_n // see RULE10 RULE11
      & (free_w > fpr_ptr_t'(we_fall));
    wptr_d = wptr_q + fpr_ptr_t'(we_fall) + fpr_ptr_t'(we_rise);
    if (apb_wr) begin
      unique case (paddr)
        `FPR_OFS_CTRL: begin
          cfg_d.fall_through_mode = pwdata[`FPR_CTRL_FALL_THROUGH_MODE_BIT];
          cfg_d.wddr = pwdata[`FPR_CTRL_WDDR_BIT];
        end
        `FPR_OFS_EMPTY_OFS: eofs_d = pwdata[ADDR_W-1:0];
        `FPR_OFS_FULL_OFS: fofs_d = pwdata[ADDR_W-1:0];
        default: ;
      endcase
    end
    if (sck_rise & ~ld_s_q[1]) begin
      {eofs_d, fofs_d} = {chain[2*ADDR_W-2:0], si_s_q[1]}; // see RULE7 RULE16
    end else if (sck_rise & ~rb_s_q[1]) begin
      so_d = chain[2*ADDR_W-1]; // see RULE8
      {eofs_d, fofs_d} = {chain[2*ADDR_W-2:0], chain[2*ADDR_W-1]};
    end
    ae_d = count >= fpr_ptr_t'(eofs_q); // see RULE14
    af_d = free_w > fpr_ptr_t'(fofs_q); // see RULE15
    ff_d = free_w > fpr_ptr_t'(1);
    pready_d = psel & ~penable;
    pslverr_d = 1'b0;
    prdata_d = prdata;
    if (psel & ~penable) begin
      prdata_d = '0;
      unique case (paddr)
        `FPR_OFS_CTRL: begin
          prdata_d[`FPR_CTRL_FALL_THROUGH_MODE_BIT] = cfg_q.fall_through_mode;
          prdata_d[`FPR_CTRL_WDDR_BIT] = cfg_q.wddr;
        end
        `FPR_OFS_STATUS: begin
          prdata_d[ADDR_W:0] = count[ADDR_W:0];
          prdata_d[`FPR_ST_AE_BIT] = almost_empty_n;
          prdata_d[`FPR_ST_AF_BIT] = almost_full_n;
          prdata_d[`FPR_ST_FF_BIT] = full_flag_n;
        end
        `FPR_OFS_EMPTY_OFS: prdata_d[ADDR_W-1:0] = eofs_q;
        `FPR_OFS_FULL_OFS: prdata_d[ADDR_W-1:0] = fofs_q;
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  // Settings survive a partial clear; the write pointer and the three level flags follow it.
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= '0;
      eofs_q <= ADDR_W'(`FPR_RST_EMPTY_OFS);
      fofs_q <= ADDR_W'(`FPR_RST_FULL_OFS);
      serial_out <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      eofs_q <= eofs_d;
      fofs_q <= fofs_d;
      serial_out <= so_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
    if (wclr) begin
      wptr_q <= '0; // see RULE13
      almost_empty_n <= 1'b0;
      almost_full_n <= 1'b1;
      full_flag_n <= 1'b1;
    end else begin
      wptr_q <= wptr_d;
      almost_empty_n <= ae_d;
      almost_full_n <= af_d;
      full_flag_n <= ff_d;
    end
    if (we_fall) begin
      mem[wptr_q[ADDR_W-1:0]] <= neg_data;
    end
    if (we_rise) begin
      mem[wptr_q[ADDR_W-1:0] + ADDR_W'(we_fall)] <= wr_port.data;
    end
  end

  // Read domain reset, clear and mode synchronisers.
  logic [1:0] rr_s_q, rc_s_q, rf_s_q;
  always_ff @(posedge rd_clk) begin
    rr_s_q <= {rr_s_q[0], rst};
    rc_s_q <= {rc_s_q[0], partial_clear_n};
    rf_s_q <= {rf_s_q[0], cfg_q.fall_through_mode};
  end
  logic rd_rst, rclr;
  assign rd_rst = rr_s_q[1];
  assign rclr = rd_rst | ~rc_s_q[1];

  fpr_ptr_t rptr_q, rptr_d, mark_ptr_q, mark_ptr_d, wptr_r, avail;
  logic mark_vld_q, mark_vld_d, ef_d, or_d, take1, take2;
  logic [DATA_W-1:0] rdat_d, rhold_q, rhold_d;
  assign avail = wptr_r - rptr_q;

  always_comb begin
    rptr_d = rptr_q;
    mark_ptr_d = mark_ptr_q;
    mark_vld_d = mark_vld_q;
    rdat_d = rd_data;
    rhold_d = rhold_q;
    take1 = ~rd_en_n & (avail != '0);
    // Reader keeps the rate select fixed, so no mid-stream change is handled.
    take2 = take1 & read_single_rate_sel & (avail > fpr_ptr_t'(1)); // see RULE1 RULE2
    if (take1) begin
      rdat_d = mem[rptr_q[ADDR_W-1:0]];
    end
    if (take2) begin
      rhold_d = mem[rptr_q[ADDR_W-1:0] + ADDR_W'(1)];
    end
    rptr_d = rptr_q + fpr_ptr_t'(take1) + fpr_ptr_t'(take2);
    if (mark) begin
      mark_ptr_d = rptr_q; // see RULE12
      mark_vld_d = 1'b1;
    end
    // Only read side state moves here; the write side learns of it by handshake.
    if (~retransmit_n) begin
      rptr_d = mark_vld_q ? mark_ptr_q : '0; // see RULE3 RULE5 RULE6
    end
    ef_d = rptr_d != wptr_r;
    or_d = rf_s_q[1] & ef_d;
    if (~retransmit_n) begin
      ef_d = rf_s_q[1]; // see RULE4
      or_d = rf_s_q[1];
    end
  end

  always_ff @(posedge rd_clk) begin
    if (rclr) begin
      rptr_q <= '0;
      mark_ptr_q <= '0;
      mark_vld_q <= 1'b0;
      rd_data <= '0; // see RULE13
      rhold_q <= '0;
      empty_flag_n <= 1'b0;
      output_ready <= 1'b0;
    end else begin
      rptr_q <= rptr_d;
      mark_ptr_q <= mark_ptr_d;
      mark_vld_q <= mark_vld_d;
      rd_data <= rdat_d;
      rhold_q <= rhold_d;
      empty_flag_n <= ef_d;
      output_ready <= or_d;
    end
  end

  // Second word of a double rate read appears on the falling edge.
  always_ff @(negedge rd_clk) begin
    rd_data_fall <= rhold_q; // see RULE1
  end

  fpr_xfer #(.W($bits(fpr_ptr_t))) u_w2r (
    .src_clk(clk),
    .src_rst(wclr),
    .src_val(wptr_q),
    .dst_clk(rd_clk),
    .dst_rst(rclr),
    .dst_val(wptr_r)
  );
  fpr_xfer #(.W($bits(fpr_ptr_t))) u_r2w ( // see RULE17
    .src_clk(rd_clk),
    .src_rst(rclr),
    .src_val(rptr_q),
    .dst_clk(clk),
    .dst_rst(wclr),
    .dst_val(rptr_w)
  );
endmodule : fpr_ctrl

// *** rtl/fpr_map.svh ***
// Purpose: Offsets, field positions, reset values and sizes of the FIFO port controller.
// Assumes: APB data is 32 bits wide and each register takes one aligned word.
// Notes: Definitions only.
`ifndef FPR_MAP_SVH
`define FPR_MAP_SVH
`define FPR_DATA_W 40
`define FPR_ADDR_W 14
`define FPR_APB_AW 12
`define FPR_OFS_CTRL 12'h000
`define FPR_OFS_STATUS 12'h004
`define FPR_OFS_EMPTY_OFS 12'h008
`define FPR_OFS_FULL_OFS 12'h00c
`define FPR_CTRL_FALL_THROUGH_MODE_BIT 0
`define FPR_CTRL_WDDR_BIT 1
`define FPR_ST_AE_BIT 16
`define FPR_ST_AF_BIT 17
`define FPR_ST_FF_BIT 18
`define FPR_RST_EMPTY_OFS 14'h007f
`define FPR_RST_FULL_OFS 14'h007f
`endif

// *** rtl/fpr_pkg.sv ***
// Purpose: Types shared by the FIFO port controller.
// Assumes: Sizes come from fpr_map.svh.
// Notes: Configuration travels as one packed struct.
`include "fpr_map.svh"
package fpr_pkg;
  typedef struct packed {
    logic wddr;
    logic fall_through_mode;
  } fpr_cfg_s;
  typedef struct packed {
    logic en_n;
    logic sel_n;
    logic [`FPR_DATA_W-1:0] data;
  } fpr_wr_s;
  typedef logic [`FPR_ADDR_W:0] fpr_ptr_t;
endpackage : fpr_pkg
